// ==== hdl/dat_cfg.svh ====
`ifndef DAT_CFG_SVH
`define DAT_CFG_SVH

// ==========================================================
// Register addresses
`define DAT_ADDR_WK_MIN 4'h8
`define DAT_ADDR_WK_HOUR 4'h9
`define DAT_ADDR_WK_MASK 4'ha
`define DAT_ADDR_DAY_MIN 4'hb
`define DAT_ADDR_DAY_HOUR 4'hc

// ==========================================================
// Field masks for readable bits
`define DAT_MIN_MASK 8'h7f
`define DAT_HOUR_MASK 8'h3f
`define DAT_WDAY_MASK 8'h7f

// ==========================================================
// Value used after reset, and the weekday code treated as invalid
`define DAT_MEM_RESET 8'h00
`define DAT_WDAY_INVALID 3'h7

`endif

// ==== hdl/dat_pkg.sv ====
package dat_pkg;

    typedef logic [3:0] dat_addr_t;
    typedef logic [7:0] dat_byte_t;

    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [2:0] weekday;
    } dat_time_s;

    typedef struct packed {
        logic wr;
        dat_addr_t addr;
        dat_byte_t data;
    } dat_wr_s;

endpackage : dat_pkg

// ==== hdl/dat_reg_mem.sv ====
`timescale 1ns/1ps
`include "dat_cfg.svh"

// ==========================================================
// Five byte alarm store with registered read data.
module dat_reg_mem
    import dat_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Write port
    input wire dat_wr_s wr_in,
    // Read port
    input wire dat_addr_t rd_addr_in,
    output dat_byte_t rd_data_out,
    // Stored fields
    output logic [6:0] wk_min_out,
    output logic [5:0] wk_hour_out,
    output logic [6:0] wk_mask_out,
    output logic [6:0] day_min_out,
    output logic [5:0] day_hour_out
);

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wk_min_out <= 7'h00;
            wk_hour_out <= 6'h00;
            wk_mask_out <= 7'h00;
            day_min_out <= 7'h00;
            day_hour_out <= 6'h00;
        end else if (wr_in.wr) begin
            if (wr_in.addr == `DAT_ADDR_WK_MIN) begin
                wk_min_out <= wr_in.data[6:0];
            end else if (wr_in.addr == `DAT_ADDR_WK_HOUR) begin
                wk_hour_out <= wr_in.data[5:0];
            end else if (wr_in.addr == `DAT_ADDR_WK_MASK) begin
                wk_mask_out <= wr_in.data[6:0];
            end else if (wr_in.addr == `DAT_ADDR_DAY_MIN) begin
                day_min_out <= wr_in.data[6:0];
            end else if (wr_in.addr == `DAT_ADDR_DAY_HOUR) begin
                day_hour_out <= wr_in.data[5:0];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rd_data_out <= `DAT_MEM_RESET;
        end else if (rd_addr_in == `DAT_ADDR_WK_MIN) begin
            rd_data_out <= {1'b0, wk_min_out};
        end else if (rd_addr_in == `DAT_ADDR_WK_HOUR) begin
            rd_data_out <= {2'b00, wk_hour_out};
        end else if (rd_addr_in == `DAT_ADDR_WK_MASK) begin
            rd_data_out <= {1'b0, wk_mask_out};
        end else if (rd_addr_in == `DAT_ADDR_DAY_MIN) begin
            rd_data_out <= {1'b0, day_min_out};
        end else if (rd_addr_in == `DAT_ADDR_DAY_HOUR) begin
            rd_data_out <= {2'b00, day_hour_out};
        end else begin
            rd_data_out <= `DAT_MEM_RESET;
        end
    end

endmodule : dat_reg_mem

// ==== hdl/dat_alarm_regs.sv ====
// ==========================================================
`timescale 1ns/1ps
`include "dat_cfg.svh"

module dat_alarm_regs
    import dat_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Register access from the serial port
    input wire logic reg_wr_in,
    input wire dat_addr_t reg_addr_in,
    input wire dat_byte_t reg_wdata_in,
    output dat_byte_t reg_rdata_out,
    // Current time from the counters
    input wire dat_time_s now_in,
    input wire logic mode_24h_in,
    // Match results and afternoon flags
    output logic wk_match_out,
    output logic day_match_out,
    output logic wk_pm_out,
    output logic day_pm_out
);

    // ==========================================================
    // Register storage.
    dat_wr_s wr_req;
    logic [6:0] wk_min;
    logic [5:0] wk_hour;
    logic [6:0] wk_mask;
    logic [6:0] day_min;
    logic [5:0] day_hour;
    logic wday_valid;
    logic wday_hit;
    logic [7:0] wk_mask_ext;
    logic wk_min_hit;
    logic wk_hour_hit;
    logic day_min_hit;
    logic day_hour_hit;

    assign wr_req = '{wr: reg_wr_in, addr: reg_addr_in, data: reg_wdata_in};

    dat_reg_mem dat_reg_mem_inst (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .wr_in(wr_req),
        .rd_addr_in(reg_addr_in),
        .rd_data_out(reg_rdata_out),
        .wk_min_out(wk_min),
        .wk_hour_out(wk_hour),
        .wk_mask_out(wk_mask),
        .day_min_out(day_min),
        .day_hour_out(day_hour)
    );

    // ==========================================================
    // Comparison against the current time.
    assign wk_mask_ext = {1'b0, wk_mask};
    assign wday_valid = (now_in.weekday != `DAT_WDAY_INVALID);
    assign wday_hit = wday_valid && wk_mask_ext[now_in.weekday];
    // Hour codes compare raw, so 12 and 32 meet the counter codes.
    assign wk_min_hit = (now_in.minute == wk_min);
    assign wk_hour_hit = (now_in.hour == wk_hour);
    assign day_min_hit = (now_in.minute == day_min);
    assign day_hour_hit = (now_in.hour == day_hour);

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wk_match_out <= 1'b0;
            day_match_out <= 1'b0;
        end else begin
            wk_match_out <= wk_min_hit && wk_hour_hit && wday_hit;
            day_match_out <= day_min_hit && day_hour_hit;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wk_pm_out <= 1'b0;
            day_pm_out <= 1'b0;
        end else begin
            wk_pm_out <= !mode_24h_in && wk_hour[5];
            day_pm_out <= !mode_24h_in && day_hour[5];
        end
    end

    // ==========================================================
    // Register write checks.
    a_wk_min_write: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == `DAT_ADDR_WK_MIN)
            |=> (wk_min == $past(reg_wdata_in[6:0])))
        else $error("weekly minute write lost");
    a_wk_hour_write: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == `DAT_ADDR_WK_HOUR)
            |=> (wk_hour == $past(reg_wdata_in[5:0])))
        else $error("weekly hour write lost");
    a_mask_write: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == `DAT_ADDR_WK_MASK)
            |=> (wk_mask == $past(reg_wdata_in[6:0])))
        else $error("mask write lost");
    a_day_min_write: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == `DAT_ADDR_DAY_MIN)
            |=> (day_min == $past(reg_wdata_in[6:0])))
        else $error("daily minute write lost");
    a_day_hour_write: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == `DAT_ADDR_DAY_HOUR)
            |=> (day_hour == $past(reg_wdata_in[5:0])))
        else $error("daily hour write lost");
    a_wk_min_held: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !(reg_wr_in && reg_addr_in == `DAT_ADDR_WK_MIN)
            |=> $stable(wk_min))
        else $error("weekly minute changed without a write");
    a_mask_held: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !(reg_wr_in && reg_addr_in == `DAT_ADDR_WK_MASK)
            |=> $stable(wk_mask))
        else $error("mask changed without a write");

    // ==========================================================
    // Register read checks.
    a_wk_min_read: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_addr_in == `DAT_ADDR_WK_MIN)
            |=> (reg_rdata_out == {1'b0, $past(wk_min)}))
        else $error("weekly minute readback wrong");
    a_wk_hour_top: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_addr_in == `DAT_ADDR_WK_HOUR)
            |=> (reg_rdata_out[7:6] == 2'b00))
        else $error("weekly hour top bits set");
    a_wk_hour_read: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_addr_in == `DAT_ADDR_WK_HOUR)
            |=> (reg_rdata_out == {2'b00, $past(wk_hour)}))
        else $error("weekly hour readback wrong");
    a_mask_read: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_addr_in == `DAT_ADDR_WK_MASK)
            |=> (reg_rdata_out == {1'b0, $past(wk_mask)}))
        else $error("mask readback wrong");
    a_day_min_read: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_addr_in == `DAT_ADDR_DAY_MIN)
            |=> (reg_rdata_out[7] == 1'b0))
        else $error("daily minute bit7 set");
    a_day_min_value: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_addr_in == `DAT_ADDR_DAY_MIN)
            |=> (reg_rdata_out == {1'b0, $past(day_min)}))
        else $error("daily minute readback wrong");
    a_day_hour_read: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (reg_addr_in == `DAT_ADDR_DAY_HOUR)
            |=> (reg_rdata_out == {2'b00, $past(day_hour)}))
        else $error("daily hour readback wrong");
    a_rsv_bit_zero: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        ((reg_addr_in == `DAT_ADDR_WK_MIN) || (reg_addr_in == `DAT_ADDR_WK_MASK)
            || (reg_addr_in == `DAT_ADDR_DAY_MIN)) |=> !reg_rdata_out[7])
        else $error("reserved bit7 read as one");
    a_rst_rdata_zero: assert property (
        @(posedge clk_sys_in)
        sys_rst_in |=> (reg_rdata_out == `DAT_MEM_RESET))
        else $error("read data not cleared by reset");

    // ==========================================================
    // Hour mode checks.
    a_pm_mode: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        mode_24h_in |=> !day_pm_out)
        else $error("afternoon flag in 24-hour mode");
    a_wk_pm_mode: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        mode_24h_in |=> !wk_pm_out)
        else $error("weekly afternoon flag in 24-hour mode");
    a_wk_pm_value: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !mode_24h_in |=> (wk_pm_out == $past(wk_hour[5])))
        else $error("weekly afternoon flag wrong");
    a_day_pm_value: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !mode_24h_in |=> (day_pm_out == $past(day_hour[5])))
        else $error("daily afternoon flag wrong");

    // ==========================================================
    // Match checks.
    a_empty_mask_quiet: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (wk_mask == 7'h00) |=> !wk_match_out)
        else $error("weekly match with empty mask");
    a_bad_wday_quiet: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (now_in.weekday == 3'h7) |=> !wk_match_out)
        else $error("weekly match on weekday code seven");
    a_day_match_time: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        ((now_in.minute == day_min) && (now_in.hour == day_hour))
            |=> day_match_out)
        else $error("daily match missed");
    a_day_match_cause: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        day_match_out
            |-> $past((now_in.minute == day_min) && (now_in.hour == day_hour)))
        else $error("daily match without cause");
    a_wk_match_cause: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        wk_match_out
            |-> $past(wk_mask_ext[now_in.weekday] && (now_in.minute == wk_min)))
        else $error("weekly match without cause");
    a_wk_match_hit: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        ((now_in.minute == wk_min) && (now_in.hour == wk_hour)
            && (now_in.weekday != 3'h7) && wk_mask_ext[now_in.weekday])
            |=> wk_match_out)
        else $error("weekly match missed");
    a_wk_hour_miss: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (now_in.hour != wk_hour) |=> !wk_match_out)
        else $error("weekly match with wrong hour");
    a_day_hour_miss: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (now_in.hour != day_hour) |=> !day_match_out)
        else $error("daily match with wrong hour");
    a_rst_match_quiet: assert property (
        @(posedge clk_sys_in)
        sys_rst_in |=> !(wk_match_out || day_match_out || wk_pm_out || day_pm_out))
        else $error("match outputs not cleared by reset");

    // ==========================================================
    // One check per valid weekday code, 0 to 6.
    for (genvar n = 0; n < 7; n++) begin : g_wday_off
        a_wday_off_quiet: assert property (
            @(posedge clk_sys_in) disable iff (sys_rst_in)
            ((now_in.weekday == 3'(n)) && !wk_mask[n])
                |=> !wk_match_out)
            else $error("weekly match on a disabled weekday");
    end

endmodule : dat_alarm_regs

// ==== tb/dat_host_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Host side of the register port.
module dat_host_model
    import dat_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Register access
    output logic reg_wr_out = 1'b0,
    output dat_addr_t reg_addr_out = 4'h0,
    output dat_byte_t reg_wdata_out = 8'h00
);
    // Writes one byte, holding the strobe for one edge.
    task automatic wr(input dat_addr_t a, input dat_byte_t d);
        @(posedge clk_sys_in);
        reg_wr_out <= 1'b1;
        reg_addr_out <= a;
        reg_wdata_out <= d;
        @(posedge clk_sys_in);
        reg_wr_out <= 1'b0;
        reg_wdata_out <= ~d;
    endtask : wr
    // Presents an address; read data is settled one edge later.
    task automatic rd(input dat_addr_t a);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        @(posedge clk_sys_in);
        #1;
    endtask : rd
endmodule : dat_host_model

// ==== tb/test_dat_alarm_regs.sv ====
`timescale 1ns/1ps
module test_dat_alarm_regs;
    import dat_pkg::*;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic mode_24h = 1'b1;
    logic reg_wr, wk_m, day_m, wk_pm, day_pm;
    dat_addr_t reg_addr;
    dat_byte_t reg_wdata, reg_rdata;
    dat_time_s now = '0;
    int num_errors = 0;
    int n_checks = 0;
    dat_byte_t wr_val [5] = '{8'hd9, 8'he3, 8'hff, 8'hd9, 8'he3};
    dat_byte_t exp_rd [5] = '{8'h59, 8'h23, 8'h7f, 8'h59, 8'h23};
    always #10 clk_sys_in = ~clk_sys_in;
    dat_host_model dat_host_model_inst (.clk_sys_in(clk_sys_in), .reg_wr_out(reg_wr),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata));
    dat_alarm_regs dat_alarm_regs_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .reg_wr_in(reg_wr), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .now_in(now), .mode_24h_in(mode_24h),
        .wk_match_out(wk_m), .day_match_out(day_m), .wk_pm_out(wk_pm), .day_pm_out(day_pm));
    // ==========================================================
    // Checking and closing.
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    // Applies a current time and samples the match outputs two edges later.
    task automatic at(input logic [6:0] m, input logic [5:0] h, input logic [2:0] w,
                      input logic [7:0] exp);
        @(posedge clk_sys_in);
        now <= {m, h, w};
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk("match", 8'({wk_m, day_m, wk_pm, day_pm}), exp);
    endtask : at
    // ==========================================================
    // Test sequence.
    initial begin
        repeat (20) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        #1;
        chk("reset match", 8'({wk_m, day_m, wk_pm, day_pm}), 8'h00);
        chk("reset read", reg_rdata, 8'h00);
        for (int i = 0; i < 5; i++) begin
            dat_host_model_inst.wr(4'h8 + 4'(i), wr_val[i]);
            dat_host_model_inst.rd(4'h8 + 4'(i));
            chk("reg", reg_rdata, exp_rd[i]);
        end
        dat_host_model_inst.wr(4'hd, 8'h55);
        dat_host_model_inst.rd(4'hd);
        chk("unmapped", reg_rdata, 8'h00);
        dat_host_model_inst.wr(4'h8, 8'h59);
        dat_host_model_inst.wr(4'h9, 8'h23);
        dat_host_model_inst.wr(4'ha, 8'h08);
        dat_host_model_inst.wr(4'hb, 8'h59);
        dat_host_model_inst.wr(4'hc, 8'h23);
        dat_host_model_inst.rd(4'ha);
        chk("mask", reg_rdata, 8'h08);
        at(7'h59, 6'h23, 3'h3, 8'h0c);
        at(7'h59, 6'h23, 3'h4, 8'h04);
        at(7'h59, 6'h23, 3'h7, 8'h04);
        at(7'h58, 6'h23, 3'h3, 8'h00);
        dat_host_model_inst.wr(4'ha, 8'h00);
        at(7'h59, 6'h23, 3'h3, 8'h04);
        @(posedge clk_sys_in);
        mode_24h <= 1'b0;
        dat_host_model_inst.wr(4'hc, 8'h32);
        at(7'h59, 6'h32, 3'h3, 8'h07);
        dat_host_model_inst.wr(4'hc, 8'h12);
        at(7'h59, 6'h12, 3'h3, 8'h06);
        dat_host_model_inst.wr(4'h9, 8'h12);
        dat_host_model_inst.wr(4'ha, 8'h41);
        at(7'h59, 6'h12, 3'h6, 8'h0c);
        at(7'h59, 6'h12, 3'h0, 8'h0c);
        at(7'h59, 6'h12, 3'h1, 8'h04);
        final_report();
    end
    initial begin
        #50000;
        num_errors++;
        final_report();
    end
endmodule : test_dat_alarm_regs
